// [diag_interrupt_section_framer.v]
/*
  Interrupt section framer: latches one alarm from the backplane and
  emits it as the closing bytes of the slave diagnosis frame. The
  section carries a four-byte type header and the cause bytes of the
  alarm; its length follows the alarm kind.
  Assumes backplane events and frame requests come from logic on
  clk_sys, and that secReq is pulsed once all earlier frame parts
  have gone out. Assumes the frame configuration inputs are steady
  while a section is being read. The master may stall the byte
  stream in any cycle.
*/
`include "diag_irq_defs.vh"

module diag_interrupt_section_framer #(
  parameter DIAG_LEN = `DIAG_REC1_BYTES
) (
  input wire clk_sys,
  input wire srst,
  input wire cfgRemInsIrq,
  input wire cfgActiveBus,
  input wire cfgModStatus,
  input wire [4:0] chanDiagCount,
  input wire evtValid,
  output wire evtReady,
  input wire [2:0] evtKind,
  input wire [7:0] evtSlot,
  input wire evtDummy,
  input wire evtChan0,
  input wire [31:0] evtRec0,
  input wire [8*(DIAG_LEN-4)-1:0] evtRec1,
  input wire [15:0] evtTypeCode,
  input wire secReq,
  output reg secNone,
  output wire secBusy,
  output wire outValid,
  input wire outReady,
  output wire [7:0] outData,
  output wire [7:0] outIndex,
  output wire outLast,
  output reg stationFail,
  output reg modChange,
  output wire alarmPending
);

  localparam MEM = `SEC_HDR_BYTES + DIAG_LEN;
  localparam integer LEN_D_RAW = `SEC_HDR_BYTES + DIAG_LEN;
  // Long records are cut so the section never outgrows its limit
  localparam integer LEN_D_CAP = (LEN_D_RAW > `SEC_MAX_BYTES) ?
    `SEC_MAX_BYTES : LEN_D_RAW;
  localparam integer LEN_H_RAW = `SEC_HDR_BYTES + `HW_INFO_BYTES;
  localparam integer LEN_R_RAW = `SEC_HDR_BYTES + `REMINS_INFO_BYTES;
  localparam [4:0] LEN_DIAG = LEN_D_CAP[4:0];
  localparam [4:0] LEN_HW = LEN_H_RAW[4:0];
  localparam [4:0] LEN_RI = LEN_R_RAW[4:0];
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  reg [1:0] state_r;
  reg pend_r;
  reg [4:0] len_r;
  reg [4:0] idx_r;
  reg [7:0] startX_r;
  reg [7:0] secMem_r [0:MEM-1];
  wire [8*MEM-1:0] fillVec;
  wire [7:0] startByte;
  wire accept;
  wire isRemIns;
  wire isDiag;
  wire isHw;
  wire isEoc;
  wire raise;
  reg [4:0] lenSel;
  reg [7:0] typeSel;
  wire bufInReady;
  wire pushByte;
  wire lastByte;
  integer k;
  reg [1:0] state_nxt;
  reg [4:0] idx_nxt;
  reg [7:0] startX_nxt;
  reg secNone_nxt;
  reg pend_nxt;
  reg [4:0] len_nxt;
  reg stationFail_nxt;
  reg modChange_nxt;
  wire [7:0] absIndex;
  wire [16:0] bufWord;

  ////////////////////////////////////////////////////////////////////
  // Event intake

  // One alarm held at a time; the next waits until it is sent
  assign evtReady = !pend_r;
  assign alarmPending = pend_r;
  assign accept = evtValid && evtReady;
  assign isRemIns = (evtKind == `KIND_PULL) || (evtKind == `KIND_PLUG);
  assign isDiag = (evtKind == `KIND_DIAG);
  assign isHw = (evtKind == `KIND_HW);
  assign isEoc = (evtKind == `KIND_EOC);
  // Changes are always taken; only the alarm is gated
  assign raise = accept && (!isRemIns ||
    (cfgRemInsIrq && !evtDummy));

  always @* begin
    case (evtKind)
      `KIND_DIAG: begin
        lenSel = LEN_DIAG;
        typeSel = `TYPE_DIAG;
      end
      `KIND_HW: begin
        lenSel = LEN_HW;
        typeSel = `TYPE_HW;
      end
      // End of cycle shares the hardware type and length
      `KIND_EOC: begin
        lenSel = LEN_HW;
        typeSel = `TYPE_HW;
      end
      `KIND_PULL: begin
        lenSel = LEN_RI;
        typeSel = `TYPE_PULL;
      end
      `KIND_PLUG: begin
        lenSel = LEN_RI;
        typeSel = `TYPE_PLUG;
      end
      default: begin
        lenSel = LEN_HW;
        typeSel = `TYPE_HW;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Additional information bytes, x+4 upward

  // Header bytes come from their own registers, not from here
  assign fillVec[8*`POS_CAUSE-1:0] = {(8*`POS_CAUSE){1'b0}};

  genvar g;
  generate
    for (g = `POS_CAUSE; g < MEM; g = g + 1) begin : fill
      if (g <= `POS_CAUSE_END) begin : cause
        wire [7:0] rec0B;
        wire [7:0] modErr;
        reg [7:0] causeB;
        assign rec0B = evtRec0[8*(g-`POS_CAUSE) +: 8];
        // Channel 0 also marks the module faulty, enable or not
        assign modErr = (g == `POS_CAUSE && isDiag && evtChan0) ?
          (8'h01 << `MOD_ERR_BIT) : 8'h00;
        always @* begin
          if (isDiag || isHw) begin
            causeB = rec0B | modErr;
          end else if (isEoc) begin
            causeB = `EOC_FILL;
          end else if (isRemIns && g == `POS_CODE_HI) begin
            causeB = evtTypeCode[15:8];
          end else begin
            causeB = 8'h00;
          end
        end
        assign fillVec[8*g +: 8] = causeB;
      end else begin : rest
        reg [7:0] restB;
        always @* begin
          if (isDiag) begin
            restB = evtRec1[8*(g-`POS_CAUSE_END-1) +: 8];
          end else if (isRemIns && g == `POS_CODE_LO) begin
            restB = evtTypeCode[7:0];
          end else begin
            restB = 8'h00;
          end
        end
        assign fillVec[8*g +: 8] = restB;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Alarm store and side effects

  // Raise and clear never meet: intake is closed while an alarm waits
  always @* begin
    pend_nxt = pend_r;
    len_nxt = len_r;
    stationFail_nxt = 1'b0;
    modChange_nxt = 1'b0;
    if (accept && isRemIns) begin
      modChange_nxt = 1'b1;
      stationFail_nxt = cfgActiveBus;
    end
    if (raise) begin
      pend_nxt = 1'b1;
      len_nxt = lenSel;
    end else if (pushByte && lastByte) begin
      pend_nxt = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      pend_r <= 1'b0;
      len_r <= 5'h00;
      stationFail <= 1'b0;
      modChange <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      len_r <= len_nxt;
      stationFail <= stationFail_nxt;
      modChange <= modChange_nxt;
    end
  end

  // Section bytes are written only on intake and read while sending
  always @(posedge clk_sys) begin
    if (srst) begin
      for (k = 0; k < MEM; k = k + 1)
        secMem_r[k] <= 8'h00;
    end else if (raise) begin
      secMem_r[`POS_LEN] <= {3'h0, lenSel};
      secMem_r[`POS_TYPE] <= typeSel;
      secMem_r[`POS_SLOT] <= evtSlot;
      secMem_r[`POS_SPEC] <= `SPEC_COMING;
      for (k = `POS_CAUSE; k < MEM; k = k + 1)
        secMem_r[k] <= fillVec[8*k +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Section emission

  section_start_calc startCalc (
    .modStatusOn(cfgModStatus),
    .chanDiagCount(chanDiagCount),
    .startByte(startByte)
  );

  assign secBusy = (state_r == ST_SEND);
  assign pushByte = secBusy && bufInReady;
  assign lastByte = (idx_r == len_r - 5'h01);

  // The start byte is taken once per request, so the frame setup may
  // change between sections but never within one
  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    startX_nxt = startX_r;
    secNone_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (secReq) begin
          startX_nxt = startByte;
          idx_nxt = 5'h00;
          if (pend_r)
            state_nxt = ST_SEND;
          else
            secNone_nxt = 1'b1;
        end
      end
      ST_SEND: begin
        // Requests while sending are ignored
        if (pushByte) begin
          idx_nxt = idx_r + 5'h01;
          if (lastByte)
            state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      idx_r <= 5'h00;
      startX_r <= 8'h00;
      secNone <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      startX_r <= startX_nxt;
      secNone <= secNone_nxt;
    end
  end

  // Index wraps past byte 255; longer frames are not supported
  assign absIndex = startX_r + {3'h0, idx_r};
  assign bufWord = {lastByte, absIndex, secMem_r[idx_r]};

  // Stall by the master holds emission; no byte is lost
  pipe_buf2 #(
    .W(17)
  ) outBuf (
    .clk_sys(clk_sys),
    .srst(srst),
    .inValid(secBusy),
    .inReady(bufInReady),
    .inData(bufWord),
    .outValid(outValid),
    .outReady(outReady),
    .outData({outLast, outIndex, outData})
  );

endmodule // diag_interrupt_section_framer

// [diag_irq_defs.vh]
/*
  Constants for the interrupt section framer: section sizes, byte
  positions, event kinds and interrupt type codes.
  Assumes it is included by bare name from each design file.
*/
`ifndef DIAG_IRQ_DEFS_VH
`define DIAG_IRQ_DEFS_VH

// Section sizes in bytes
`define SEC_MAX_BYTES 29
`define SEC_HDR_BYTES 4
`define DIAG_REC1_BYTES 16
`define HW_INFO_BYTES 4
`define REMINS_INFO_BYTES 5

// Start byte of the section within the frame
`define SEC_BASE_BYTE 9
`define MODSTAT_BYTES 5
`define CHANDIAG_BYTES 3

// Byte positions inside the section
`define POS_LEN 0
`define POS_TYPE 1
`define POS_SLOT 2
`define POS_SPEC 3
`define POS_CAUSE 4
`define POS_CAUSE_END 7
`define POS_CODE_HI 7
`define POS_CODE_LO 8
`define MOD_ERR_BIT 0

// Event kinds from the backplane
`define KIND_DIAG 3'h0
`define KIND_HW 3'h1
`define KIND_EOC 3'h2
`define KIND_PULL 3'h3
`define KIND_PLUG 3'h4

// Interrupt type codes placed in the type byte
`define TYPE_DIAG 8'h01
`define TYPE_HW 8'h02
`define TYPE_PULL 8'h03
`define TYPE_PLUG 8'h04
`define SPEC_COMING 8'h01
`define EOC_FILL 8'hFF

`endif

// [pipe_buf2.v]
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`include "diag_irq_defs.vh"

module pipe_buf2 #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);

  reg [W-1:0] ent0_r;
  reg [W-1:0] ent1_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign inReady = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData = ent0_r;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= 2'h0;
      ent0_r <= {W{1'b0}};
      ent1_r <= {W{1'b0}};
    end else begin
      // Head slot always holds the oldest word
      if (pop) begin
        ent0_r <= (cnt_r == 2'h2) ? ent1_r : inData;
        if (push && cnt_r == 2'h2)
          ent1_r <= inData;
      end else if (push) begin
        if (cnt_r == 2'h0)
          ent0_r <= inData;
        else
          ent1_r <= inData;
      end
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule // pipe_buf2

// [section_start_calc.v]
/*
  Start byte of the interrupt section within the diagnosis frame.
  Assumes the configuration inputs are steady while a frame is read.
*/
`include "diag_irq_defs.vh"

module section_start_calc (
  input wire modStatusOn,
  input wire [4:0] chanDiagCount,
  output wire [7:0] startByte
);

  localparam integer MODSTAT_I = `MODSTAT_BYTES;
  localparam integer CHAN_I = `CHANDIAG_BYTES;
  localparam integer BASE_I = `SEC_BASE_BYTE;
  localparam [7:0] MODSTAT_B = MODSTAT_I[7:0];
  localparam [7:0] CHAN_B = CHAN_I[7:0];
  localparam [7:0] BASE_B = BASE_I[7:0];

  wire [7:0] modPart;
  wire [7:0] chanPart;

  assign modPart = modStatusOn ? MODSTAT_B : 8'h00;
  assign chanPart = {3'h0, chanDiagCount} * CHAN_B;
  assign startByte = BASE_B + modPart + chanPart;

endmodule // section_start_calc

// [framer_chk.sv]
/* Assertions on the interrupt section framer ports.
   Assumes one clock, clk_sys, and the synchronous reset srst. */
`include "diag_irq_defs.vh"

module framer_chk #(
  parameter DIAG_LEN = 16
) (
  input wire clk_sys,
  input wire srst,
  input wire cfgActiveBus,
  input wire evtValid,
  input wire evtReady,
  input wire [2:0] evtKind,
  input wire evtDummy,
  input wire secReq,
  input wire secNone,
  input wire secBusy,
  input wire outValid,
  input wire outReady,
  input wire [7:0] outData,
  input wire [7:0] outIndex,
  input wire outLast,
  input wire stationFail,
  input wire modChange,
  input wire alarmPending
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LenDiag = DIAG_LEN + 4 > 29 ? 29 : DIAG_LEN + 4;
  logic inSec_r;
  logic [7:0] lastIdx_r;
  wire take = outValid && outReady;
  wire evtTake = evtValid && evtReady;
  wire remIns = evtKind == `KIND_PULL || evtKind == `KIND_PLUG;
  // Marks bytes after the first, so the first can be judged alone
  always @(posedge clk_sys) begin
    inSec_r <= !srst && (take ? !outLast : inSec_r);
    if (take)
      lastIdx_r <= outIndex;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  ////////////////////////////////
  chk_alarm_latch: assert property (
    evtTake && evtKind == `KIND_DIAG |=> alarmPending && !evtReady)
    else $error("no alarm latched");
  chk_none_pulse: assert property (
    secReq && !secBusy && !alarmPending |=> secNone && !secBusy)
    else $error("no empty answer");
  chk_sec_start: assert property (
    secReq && !secBusy && alarmPending |=> secBusy ##1 outValid)
    else $error("late section");
  chk_station_fail: assert property (
    evtTake && remIns && cfgActiveBus |=> stationFail && modChange)
    else $error("no station failure");
  chk_dummy_quiet: assert property (
    evtTake && remIns && evtDummy |=> !alarmPending)
    else $error("dummy raised alarm");
  chk_first_len: assert property (
    outValid && !inSec_r |-> outData inside {8'h08, 8'h09, 8'(LenDiag)})
    else $error("bad length byte");
  chk_index_step: assert property (
    outValid && inSec_r |-> outIndex == lastIdx_r + 8'h01)
    else $error("index not ascending");
  chk_stall_hold: assert property (
    outValid && !outReady |=> outValid && $stable(outData) && $stable(outIndex))
    else $error("stalled byte changed");
  cover property (outValid && !outReady);
  cover property (secNone);
  cover property (stationFail);
endmodule // framer_chk

bind diag_interrupt_section_framer framer_chk #(.DIAG_LEN(DIAG_LEN)) i_framer_chk (.*);

// [diag_master.sv]
/* Bus master model: asks for the interrupt section and collects it.
   Assumes clk_sys from the bench; drives only after falling edges. */
module diag_master (
  input wire clk_sys,
  input wire outValid,
  input wire [7:0] outData,
  input wire [7:0] outIndex,
  input wire outLast,
  input wire secNone,
  output logic secReq = 1'b0,
  output logic outReady = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dat[$];
  logic [7:0] idx[$];
  logic none;
  logic lastSeen;
  ////////////////////////////////
  // Slow mode stalls every other cycle so the buffer must hold
  task automatic fetch(input logic slow);
    dat = {};
    idx = {};
    none = 1'b0;
    lastSeen = 1'b0;
    secReq = 1'b1;
    for (int n = 0; n < 99; n++) begin
      @(negedge clk_sys);
      secReq = 1'b0;
      outReady = !(slow && n[0]);
      none = none | secNone;
      if (outValid && outReady) begin
        dat.push_back(outData);
        idx.push_back(outIndex);
        lastSeen = outLast;
      end
      if (none || (outValid && outReady && outLast))
        break;
    end
  endtask
endmodule // diag_master

// [tb_top.sv]
/* Self-checking bench for the interrupt section framer.
   Assumes the design files, diag_master and framer_chk are compiled. */
`include "diag_irq_defs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, srst, cfgRemInsIrq, cfgActiveBus, cfgModStatus;
  logic [4:0] chanDiagCount;
  logic evtValid, evtDummy, evtChan0;
  logic [2:0] evtKind;
  logic [31:0] evtRec0 = 32'hA1B2C3D4;
  logic [95:0] evtRec1 = 96'h0F1E2D3C4B5A69788796A5B4;
  logic [15:0] evtTypeCode = 16'h8C4D;
  logic [7:0] evtSlot = 8'h05;
  wire evtReady, secReq, secNone, secBusy, outValid, outReady, outLast;
  wire stationFail, modChange, alarmPending;
  wire [7:0] outData, outIndex;
  int bad_count = 0;
  int compares = 0;
  diag_interrupt_section_framer i_diag_interrupt_section_framer (.*);
  diag_master i_diag_master (.*);
  ////////////////////////////////
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Returns at the falling edge after the take, where pulses show
  task automatic offer(input logic [2:0] k, input logic dummy, input logic chan0);
    @(negedge clk_sys);
    {evtKind, evtDummy, evtChan0, evtValid} = {k, dummy, chan0, 1'b1};
    for (int n = 0; n < 50 && evtReady !== 1'b1; n++)
      @(negedge clk_sys);
    @(negedge clk_sys);
    evtValid = 1'b0;
  endtask
  task automatic judge(input logic [2:0] k, input logic c);
    logic [7:0] e[$];
    logic [7:0] x;
    logic [31:0] cz;
    x = 8'h09 + (cfgModStatus ? 8'h05 : 8'h00) + 8'h03 * chanDiagCount;
    cz = k == `KIND_EOC ? 32'hFFFFFFFF : evtRec0 | {31'h0, c && k == `KIND_DIAG};
    cz = k >= `KIND_PULL ? {evtTypeCode[15:8], 24'h0} : cz;
    e = {k == `KIND_DIAG ? 8'h14 : k >= `KIND_PULL ? 8'h09 : 8'h08, k == `KIND_PULL ? `TYPE_PULL
      : k == `KIND_PLUG ? `TYPE_PLUG : k == `KIND_DIAG ? `TYPE_DIAG : `TYPE_HW, evtSlot, 8'h01};
    for (int i = 0; i < 4; i++)
      e.push_back(cz[8*i+:8]);
    for (int i = 0; i < 12 && k == `KIND_DIAG; i++)
      e.push_back(evtRec1[8*i+:8]);
    if (k >= `KIND_PULL)
      e.push_back(evtTypeCode[7:0]);
    ck("count", 8'(e.size()), 8'(i_diag_master.dat.size()));
    ck("outLast", 8'h01, {7'h00, i_diag_master.lastSeen});
    for (int i = 0; i < e.size(); i++) begin
      ck("byte", e[i], i_diag_master.dat[i]);
      ck("index", x + 8'(i), i_diag_master.idx[i]);
    end
  endtask
  ////////////////////////////////
  task automatic t_diag;
    {cfgModStatus, chanDiagCount} = {1'b1, 5'h02};
    offer(`KIND_DIAG, 1'b0, 1'b1);
    ck("evtReady", 8'h00, {7'h00, evtReady});
    i_diag_master.fetch(1'b1);
    judge(`KIND_DIAG, 1'b1);
  endtask
  task automatic t_hw;
    {cfgModStatus, chanDiagCount} = 6'h00;
    offer(`KIND_HW, 1'b0, 1'b0);
    i_diag_master.fetch(1'b0);
    judge(`KIND_HW, 1'b0);
    offer(`KIND_EOC, 1'b0, 1'b1);
    i_diag_master.fetch(1'b1);
    judge(`KIND_EOC, 1'b1);
  endtask
  task automatic t_remins;
    {cfgRemInsIrq, cfgActiveBus} = 2'h3;
    for (int j = 0; j < 2; j++) begin
      offer(3'(`KIND_PULL + j), 1'b0, 1'b0);
      ck("stationFail", 8'h01, {7'h00, stationFail});
      i_diag_master.fetch(1'b0);
      judge(3'(`KIND_PULL + j), 1'b0);
    end
  endtask
  task automatic t_quiet;
    {cfgRemInsIrq, cfgActiveBus} = 2'h1;
    offer(`KIND_PULL, 1'b0, 1'b0);
    ck("change", 8'h03, {6'h00, modChange, stationFail});
    ck("alarmPending", 8'h00, {7'h00, alarmPending});
    cfgRemInsIrq = 1'b1;
    offer(`KIND_PLUG, 1'b1, 1'b0);
    i_diag_master.fetch(1'b0);
    ck("none", 8'h01, {7'h00, i_diag_master.none});
  endtask
  // Reset in mid-run drops a latched alarm
  task automatic t_reset;
    offer(`KIND_HW, 1'b0, 1'b0);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    ck("resetState", 8'h02, {6'h00, evtReady, alarmPending});
    i_diag_master.fetch(1'b0);
    ck("resetNone", 8'h01, {7'h00, i_diag_master.none});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Tests need some 120 cycles; 25-fold margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
  initial begin
    {srst, cfgRemInsIrq, cfgActiveBus, cfgModStatus, chanDiagCount} = 9'h100;
    {evtValid, evtDummy, evtChan0, evtKind} = 6'h00;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    t_diag();
    t_hw();
    t_remins();
    t_quiet();
    t_reset();
    print_verdict();
  end
endmodule // tb_top
